// [verilog/fsfb_bank.sv]
`timescale 1ns/10ps
`include "fsfb_defs.svh"

// Overview of operation
// R01 - each status register uses single-byte write and read by command code
// R02 - read of 7Ch returns input-supply flags
// R03 - input flags clear by clear-all command or write-one
// R04 - a still-present fault sets its flag again at once
// R05 - input bit 7 latches on input overvoltage, resets zero
// R06 - input bit 4 latches on input undervoltage, resets zero
// R07 - input bit 0 latches on input overpower, resets zero
// R08 - unsupported input and temperature bits always read zero
// R09 - read of 7Dh returns temperature flags, cleared same way
// R10 - temperature bit 7 latches when temperature exceeds fault threshold
// R11 - temperature bit 6 latches when temperature exceeds warn threshold
// R12 - read of 80h returns vendor flags; all but bits 7 and 1 clearable
// R13 - vendor bit 7 is live: one in discontinuous conduction
// R14 - flags have no backup and update while running
// R15 - overpower flag set when input power exceeds warn limit
// R16 - vendor bit 2 latches after negative overcurrent cycle
// R17 - vendor bit 1 follows power-stage overtemperature comparator live
// R18 - vendor bit 3 latches on power-on restore error
// R19 - writing zero or to read-only bits changes nothing
module fsfb_bank
  import fsfb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire fsfb_pkg::fsfb_byte_t cmd_i,
  input wire fsfb_pkg::fsfb_byte_t wdata_i,
  input wire logic input_ov_i,
  input wire logic input_uv_i,
  input wire logic [7:0] input_power_i,
  input wire logic [7:0] input_power_limit_i,
  input wire logic [7:0] temperature_i,
  input wire logic [7:0] overtemp_fault_threshold_i,
  input wire logic [7:0] overtemp_warn_threshold_i,
  input wire logic discontinuous_conduction_live_i,
  input wire logic controller_analog_overtemp_i,
  input wire logic power_stage_fault_i,
  input wire logic die_link_error_i,
  input wire logic restore_error_i,
  input wire logic negative_overcurrent_i,
  input wire logic power_stage_overtemp_i,
  input wire logic driver_supply_uv_i,
  output fsfb_pkg::fsfb_byte_t rdata_o,
  output logic rvalid_o,
  output logic cmd_ack_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    fsfb_byte_t rdata;
    logic rvalid;
    logic ack;
    logic discontinuous_conduction_live;
    logic psot;
  } fsfb_bank_state_t;

  fsfb_bank_state_t st_r;
  fsfb_bank_state_t st_nxt;

  fsfb_byte_t clr_in;
  fsfb_byte_t clr_tmp;
  fsfb_byte_t clr_vs;
  fsfb_byte_t set_in;
  fsfb_byte_t set_tmp;
  fsfb_byte_t set_vs;
  fsfb_byte_t in_flags;
  fsfb_byte_t tmp_flags;
  fsfb_byte_t vs_flags;
  fsfb_byte_t vs_view;
  logic clear_all;

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  // R15 digital compare against overpower limit
  // R05 R06 R07 input flag sources
  always_comb
  begin
    set_in = 8'h00;
    set_in[`FSFB_IN_OVF_BIT] = input_ov_i;
    set_in[`FSFB_IN_UVF_BIT] = input_uv_i;
    set_in[`FSFB_IN_OPW_BIT] = input_power_i > input_power_limit_i;
  end

  // R10 R11 digital temperature compares
  always_comb
  begin
    set_tmp = 8'h00;
    set_tmp[`FSFB_TMP_OTF_BIT] = temperature_i > overtemp_fault_threshold_i;
    set_tmp[`FSFB_TMP_OTW_BIT] = temperature_i > overtemp_warn_threshold_i;
  end

  // R16 R18 latched vendor sources; bits 7 and 1 are live
  assign set_vs = {1'b0, controller_analog_overtemp_i, power_stage_fault_i,
                   die_link_error_i, restore_error_i, negative_overcurrent_i,
                   1'b0, driver_supply_uv_i};

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  // R03 R09 R12 global clear command clears every latched flag
  assign clear_all = wr_i && cmd_i == `FSFB_CMD_CLEAR;

  // R19 zero bits in the write leave flags alone
  fsfb_cmd_decode u_dec (
    .wr_i(wr_i),
    .cmd_i(cmd_i),
    .wdata_i(wdata_i),
    .clear_all_i(clear_all),
    .clr_in_o(clr_in),
    .clr_tmp_o(clr_tmp),
    .clr_vs_o(clr_vs)
  );

  // ------------------------------------------------------------
  // flag bytes
  // ------------------------------------------------------------
  // R04 R08 set beats clear, unsupported bits masked to zero
  fsfb_flag_reg u_in (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .mask_i(`FSFB_IN_MASK),
    .set_i(set_in),
    .clr_i(clr_in),
    .flags_o(in_flags)
  );

  fsfb_flag_reg u_tmp (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .mask_i(`FSFB_TMP_MASK),
    .set_i(set_tmp),
    .clr_i(clr_tmp),
    .flags_o(tmp_flags)
  );

  fsfb_flag_reg u_vs (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .mask_i(`FSFB_VS_LATCH_MASK),
    .set_i(set_vs),
    .clr_i(clr_vs),
    .flags_o(vs_flags)
  );

  // R13 R17 live bits merged, never latched or cleared
  always_comb
  begin
    vs_view = vs_flags;
    vs_view[`FSFB_VS_DCM_BIT] = st_r.discontinuous_conduction_live;
    vs_view[`FSFB_VS_PSOT_BIT] = st_r.psot;
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.discontinuous_conduction_live = discontinuous_conduction_live_i;
    st_nxt.psot = power_stage_overtemp_i;
    st_nxt.rvalid = 1'b0;
    st_nxt.ack = wr_i;
    // R01 R02 R09 R12 one byte per read; unknown codes read zero
    if (rd_i)
    begin
      st_nxt.rvalid = 1'b1;
      if (cmd_i == `FSFB_CMD_INPUT)
        st_nxt.rdata = in_flags;
      else if (cmd_i == `FSFB_CMD_TEMP)
        st_nxt.rdata = tmp_flags;
      else if (cmd_i == `FSFB_CMD_VENDOR)
        st_nxt.rdata = vs_view;
      else
        st_nxt.rdata = 8'h00;
    end
  end

  // R14 plain flops, no backup; values follow operation
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;
  assign rvalid_o = st_r.rvalid;
  assign cmd_ack_o = st_r.ack;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_ovf_latch: assert property ( // R05
    @(posedge clock_i) disable iff (!rst_n_i)
    input_ov_i |=> in_flags[`FSFB_IN_OVF_BIT])
    else $error("overvoltage flag not latched");
  chk_uvf_latch: assert property ( // R06
    @(posedge clock_i) disable iff (!rst_n_i)
    input_uv_i |=> in_flags[`FSFB_IN_UVF_BIT])
    else $error("undervoltage flag not latched");
  chk_opw_compare: assert property ( // R15
    @(posedge clock_i) disable iff (!rst_n_i)
    (input_power_i > input_power_limit_i) |=> in_flags[0])
    else $error("overpower flag not latched");
  chk_otf_compare: assert property ( // R10
    @(posedge clock_i) disable iff (!rst_n_i)
    (temperature_i > overtemp_fault_threshold_i) |=> tmp_flags[7])
    else $error("overtemp fault not latched");
  chk_otw_compare: assert property ( // R11
    @(posedge clock_i) disable iff (!rst_n_i)
    (temperature_i > overtemp_warn_threshold_i) |=> tmp_flags[6])
    else $error("overtemp warn not latched");
  chk_clear_all: assert property ( // R03
    @(posedge clock_i) disable iff (!rst_n_i)
    (clear_all && !input_ov_i) |=> !in_flags[7])
    else $error("clear command ignored");
  chk_relatch: assert property ( // R04
    @(posedge clock_i) disable iff (!rst_n_i)
    (clear_all && input_uv_i) |=> in_flags[4])
    else $error("standing fault lost on clear");
  chk_reserved_zero: assert property ( // R08
    @(posedge clock_i) disable iff (!rst_n_i)
    (in_flags & 8'h6e) == 8'h00 && (tmp_flags & 8'h3f) == 8'h00)
    else $error("reserved bit set");
  chk_dcm_live: assert property ( // R13
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i && cmd_i == `FSFB_CMD_VENDOR |=>
      rdata_o[7] == $past(st_r.discontinuous_conduction_live))
    else $error("live mode bit wrong");
  chk_read_one: assert property ( // R01
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i |=> rvalid_o ##1 (!rvalid_o || $past(rd_i)))
    else $error("read answer not single cycle");
  chk_write_zero: assert property ( // R19
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_i && cmd_i == `FSFB_CMD_TEMP && wdata_i == 8'h00) |=>
      tmp_flags == ($past(tmp_flags) | $past(set_tmp)))
    else $error("zero write changed flags");
  chk_noc_latch: assert property ( // R16
    @(posedge clock_i) disable iff (!rst_n_i)
    negative_overcurrent_i |=> vs_flags[2])
    else $error("negative overcurrent not latched");
  chk_restore_latch: assert property ( // R18
    @(posedge clock_i) disable iff (!rst_n_i)
    restore_error_i |=> vs_flags[3])
    else $error("restore error not latched");
  chk_psot_live: assert property ( // R17
    @(posedge clock_i) disable iff (!rst_n_i)
    power_stage_overtemp_i |=> st_r.psot)
    else $error("stage overtemp not followed");
  chk_input_read: assert property ( // R02
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i && cmd_i == `FSFB_CMD_INPUT |=> rdata_o == $past(in_flags))
    else $error("input read wrong");
  chk_vs_clear: assert property ( // R12
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_i && cmd_i == `FSFB_CMD_VENDOR && wdata_i[5]
      && !power_stage_fault_i) |=> !vs_flags[5])
    else $error("vendor flag not cleared");
  chk_temp_clear: assert property ( // R09
    @(posedge clock_i) disable iff (!rst_n_i)
    (wr_i && cmd_i == `FSFB_CMD_TEMP && wdata_i[7] &&
      !(temperature_i > overtemp_fault_threshold_i)) |=> !tmp_flags[7])
    else $error("temperature flag not cleared");
  chk_stays_set: assert property ( // R14
    @(posedge clock_i) disable iff (!rst_n_i)
    in_flags[7] && !wr_i |=> in_flags[7])
    else $error("flag dropped without clear");
  chk_write_ack: assert property ( // R01
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_i |=> cmd_ack_o)
    else $error("write not acknowledged");
  chk_ack_single: assert property ( // R01
    @(posedge clock_i) disable iff (!rst_n_i)
    !wr_i |=> !cmd_ack_o)
    else $error("stray write acknowledge");
  chk_rdata_hold: assert property ( // R01
    @(posedge clock_i) disable iff (!rst_n_i)
    !rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property ( // R01
    @(posedge clock_i) disable iff (!rst_n_i)
    (rd_i && cmd_i != `FSFB_CMD_INPUT && cmd_i != `FSFB_CMD_TEMP &&
      cmd_i != `FSFB_CMD_VENDOR) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_temp_read: assert property ( // R09
    @(posedge clock_i) disable iff (!rst_n_i)
    rd_i && cmd_i == `FSFB_CMD_TEMP |=> rdata_o == $past(tmp_flags))
    else $error("temperature read wrong");
  chk_dcm_follow: assert property ( // R13
    @(posedge clock_i) disable iff (!rst_n_i)
    1'b1 |=> st_r.discontinuous_conduction_live == $past(discontinuous_conduction_live_i))
    else $error("live mode bit not following");
  chk_psot_clear: assert property ( // R17
    @(posedge clock_i) disable iff (!rst_n_i)
    !power_stage_overtemp_i |=> !st_r.psot)
    else $error("stage overtemp stuck");
  chk_clear_vs: assert property ( // R12
    @(posedge clock_i) disable iff (!rst_n_i)
    (clear_all && !restore_error_i) |=> !vs_flags[3])
    else $error("vendor flag survives clear command");

  cov_ov_clear: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    in_flags[7] ##1 (wr_i && cmd_i == `FSFB_CMD_INPUT) ##1 !in_flags[7]);
  cov_relatch: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    clear_all && input_uv_i);
  cov_vs_read: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    rd_i && cmd_i == `FSFB_CMD_VENDOR && st_r.discontinuous_conduction_live);
  cov_temp_both: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    tmp_flags == 8'hc0);
  cov_zero_write: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    wr_i && cmd_i == `FSFB_CMD_TEMP && wdata_i == 8'h00);
endmodule : fsfb_bank

// [verilog/fsfb_defs.svh]
`ifndef FSFB_DEFS_SVH
`define FSFB_DEFS_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define FSFB_CMD_INPUT 8'h7c
`define FSFB_CMD_TEMP 8'h7d
`define FSFB_CMD_VENDOR 8'h80
`define FSFB_CMD_CLEAR 8'h03

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FSFB_IN_OVF_BIT 7
`define FSFB_IN_UVF_BIT 4
`define FSFB_IN_OPW_BIT 0
`define FSFB_TMP_OTF_BIT 7
`define FSFB_TMP_OTW_BIT 6
`define FSFB_VS_DCM_BIT 7
`define FSFB_VS_PSOT_BIT 1

// ------------------------------------------------------------
// supported-bit masks and reset values
// ------------------------------------------------------------
`define FSFB_IN_MASK 8'h91
`define FSFB_TMP_MASK 8'hc0
`define FSFB_VS_LATCH_MASK 8'h7d
`define FSFB_RESET_VAL 8'h00

`endif

// [verilog/fsfb_pkg.sv]
package fsfb_pkg;

  typedef logic [7:0] fsfb_byte_t;

  typedef enum logic [2:0] {
    FSFB_IN = 3'b001,
    FSFB_TMP = 3'b010,
    FSFB_VS = 3'b100
  } fsfb_reg_sel_t;

endpackage : fsfb_pkg

// [verilog/fsfb_flag_reg.sv]
`timescale 1ns/10ps
`include "fsfb_defs.svh"

// one byte of sticky flags with write-one-to-clear
module fsfb_flag_reg
  import fsfb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire fsfb_pkg::fsfb_byte_t mask_i,
  input wire fsfb_pkg::fsfb_byte_t set_i,
  input wire fsfb_pkg::fsfb_byte_t clr_i,
  output fsfb_pkg::fsfb_byte_t flags_o
);
  typedef struct packed {
    fsfb_byte_t flags;
  } fsfb_fr_state_t;

  fsfb_fr_state_t st_r;
  fsfb_fr_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    // set wins over clear; a standing fault relatches at once
    st_nxt.flags = ((st_r.flags & ~clr_i) | set_i) & mask_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '{flags: `FSFB_RESET_VAL};
    else
      st_r <= st_nxt;
  end

  assign flags_o = st_r.flags;

  chk_set_wins: assert property ( // R04
    @(posedge clock_i) disable iff (!rst_n_i)
    ((set_i & mask_i) != 8'h00) |=>
      ((flags_o & $past(set_i & mask_i)) == $past(set_i & mask_i)))
    else $error("flag set lost");
  chk_masked_zero: assert property ( // R08
    @(posedge clock_i) disable iff (!rst_n_i)
    (flags_o & ~mask_i) == 8'h00)
    else $error("unsupported bit set");
endmodule : fsfb_flag_reg

// [verilog/fsfb_cmd_decode.sv]
`timescale 1ns/10ps
`include "fsfb_defs.svh"

// turns a byte write into per-register clear masks
module fsfb_cmd_decode
  import fsfb_pkg::*;
(
  input wire logic wr_i,
  input wire fsfb_pkg::fsfb_byte_t cmd_i,
  input wire fsfb_pkg::fsfb_byte_t wdata_i,
  input wire logic clear_all_i,
  output fsfb_pkg::fsfb_byte_t clr_in_o,
  output fsfb_pkg::fsfb_byte_t clr_tmp_o,
  output fsfb_pkg::fsfb_byte_t clr_vs_o
);
  always_comb
  begin
    clr_in_o = 8'h00;
    clr_tmp_o = 8'h00;
    clr_vs_o = 8'h00;
    if (clear_all_i)
    begin
      clr_in_o = 8'hff;
      clr_tmp_o = 8'hff;
      clr_vs_o = 8'hff;
    end
    else if (wr_i && cmd_i == `FSFB_CMD_INPUT)
      clr_in_o = wdata_i;
    else if (wr_i && cmd_i == `FSFB_CMD_TEMP)
      clr_tmp_o = wdata_i;
    else if (wr_i && cmd_i == `FSFB_CMD_VENDOR)
      clr_vs_o = wdata_i;
  end
endmodule : fsfb_cmd_decode

// [verif/fsfb_host_model.sv]
`timescale 1ns/10ps

// ------------------------------------------------------------
// host controller side of the byte access port
// ------------------------------------------------------------
module fsfb_host_model
  import fsfb_pkg::*;
(
  input wire logic clock_i,
  input wire logic rvalid_i,
  input wire logic ack_i,
  input wire fsfb_pkg::fsfb_byte_t rdata_i,
  output logic wr_o,
  output logic rd_o,
  output fsfb_pkg::fsfb_byte_t cmd_o,
  output fsfb_pkg::fsfb_byte_t wdata_o
);
  int bus_err;

  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 8'h00;
    bus_err = 0;
  end

  task automatic wr_byte(input fsfb_byte_t c, input fsfb_byte_t d);
    @(posedge clock_i);
    #1;
    wr_o = 1'b1;
    cmd_o = c;
    wdata_o = d;
    @(posedge clock_i);
    #1;
    wr_o = 1'b0;
    // released lines show junk, not the old value
    cmd_o = ~c;
    wdata_o = ~d;
    if (ack_i !== 1'b1)
    begin
      $display("ERROR %0t: write not acknowledged", $time);
      bus_err++;
    end
  endtask : wr_byte

  task automatic rd_byte(input fsfb_byte_t c, output fsfb_byte_t d);
    @(posedge clock_i);
    #1;
    rd_o = 1'b1;
    cmd_o = c;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
    cmd_o = ~c;
    d = rdata_i;
    if (rvalid_i !== 1'b1)
    begin
      $display("ERROR %0t: read not answered", $time);
      bus_err++;
    end
  endtask : rd_byte
endmodule : fsfb_host_model

// [verif/fsfb_bank_tb_top.sv]
`timescale 1ns/10ps

module fsfb_bank_tb_top;
  import fsfb_pkg::*;
  logic clock_i, rst_n_i, wr, rd, rv, ack;
  logic ov, uv, discontinuous_conduction_live, caot, psf, dle, rse, negative_overcurrent_flag, psot, dsuv;
  logic [7:0] pw, pwl, tmp, tf, tw;
  fsfb_byte_t cmd, wd, rdat;
  int err_count = 0;
  int n_compared = 0;

  fsfb_bank fsfb_bank_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_i(wr), .rd_i(rd),
    .cmd_i(cmd), .wdata_i(wd), .input_ov_i(ov), .input_uv_i(uv),
    .input_power_i(pw), .input_power_limit_i(pwl), .temperature_i(tmp),
    .overtemp_fault_threshold_i(tf), .overtemp_warn_threshold_i(tw),
    .discontinuous_conduction_live_i(discontinuous_conduction_live),
    .controller_analog_overtemp_i(caot), .power_stage_fault_i(psf),
    .die_link_error_i(dle), .restore_error_i(rse),
    .negative_overcurrent_i(negative_overcurrent_flag), .power_stage_overtemp_i(psot),
    .driver_supply_uv_i(dsuv), .rdata_o(rdat), .rvalid_o(rv),
    .cmd_ack_o(ack)
  );

  fsfb_host_model fsfb_host_model_inst (
    .clock_i(clock_i), .rvalid_i(rv), .ack_i(ack), .rdata_i(rdat),
    .wr_o(wr), .rd_o(rd), .cmd_o(cmd), .wdata_o(wd)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic rd_chk(input fsfb_byte_t c, input fsfb_byte_t exp);
    fsfb_byte_t got;
    fsfb_host_model_inst.rd_byte(c, got);
    n_compared++;
    if (got !== exp)
    begin
      $display("ERROR %0t: cmd %h read %h expected %h", $time, c, got, exp);
      err_count++;
    end
  endtask : rd_chk

  task automatic wr_cmd(input fsfb_byte_t c, input fsfb_byte_t d);
    fsfb_host_model_inst.wr_byte(c, d);
  endtask : wr_cmd

  task automatic print_verdict;
    err_count += fsfb_host_model_inst.bus_err;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // ------------------------------------------------------------
  // clock, watchdog
  // ------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // whole run needs well under 4000 cycles
  initial
  begin
    #20000;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    rst_n_i = 1'b0;
    {ov, uv, discontinuous_conduction_live, caot, psf, dle, rse, negative_overcurrent_flag, psot, dsuv} = '0;
    pw = 8'h20;
    pwl = 8'h20;
    tmp = 8'h40;
    tf = 8'h60;
    tw = 8'h40;
    tick(12);
    rst_n_i = 1'b1;
    rd_chk(8'h7c, 8'h00);
    rd_chk(8'h7d, 8'h00);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h55, 8'h00);
    wr_cmd(8'h55, 8'hff);
    $display("test reset values done");
    ov = 1'b1;
    uv = 1'b1;
    pw = 8'h21;
    tick(1);
    ov = 1'b0;
    pw = 8'h20;
    rd_chk(8'h7c, 8'h91);
    wr_cmd(8'h7c, 8'h80);
    rd_chk(8'h7c, 8'h11);
    wr_cmd(8'h7c, 8'h6e);
    rd_chk(8'h7c, 8'h11);
    wr_cmd(8'h7c, 8'h10);
    rd_chk(8'h7c, 8'h11);
    wr_cmd(8'h03, 8'h00);
    rd_chk(8'h7c, 8'h10);
    uv = 1'b0;
    wr_cmd(8'h03, 8'h00);
    rd_chk(8'h7c, 8'h00);
    $display("test input flags done");
    tmp = 8'h60;
    tick(1);
    rd_chk(8'h7d, 8'h40);
    tmp = 8'h61;
    tick(1);
    rd_chk(8'h7d, 8'hc0);
    tmp = 8'h00;
    wr_cmd(8'h7d, 8'h3f);
    rd_chk(8'h7d, 8'hc0);
    wr_cmd(8'h7d, 8'h00);
    rd_chk(8'h7d, 8'hc0);
    wr_cmd(8'h7d, 8'hff);
    rd_chk(8'h7d, 8'h00);
    $display("test temperature flags done");
    {caot, psf, dle, rse, negative_overcurrent_flag, dsuv, discontinuous_conduction_live, psot} = '1;
    tick(1);
    {caot, psf, dle, rse, negative_overcurrent_flag, dsuv} = '0;
    rd_chk(8'h80, 8'hff);
    wr_cmd(8'h80, 8'hff);
    rd_chk(8'h80, 8'h82);
    discontinuous_conduction_live = 1'b0;
    psot = 1'b0;
    tick(1);
    rd_chk(8'h80, 8'h00);
    rse = 1'b1;
    tick(1);
    rse = 1'b0;
    rd_chk(8'h80, 8'h08);
    wr_cmd(8'h03, 8'h00);
    rd_chk(8'h80, 8'h00);
    $display("test vendor flags done");
    ov = 1'b1;
    tick(1);
    ov = 1'b0;
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    rd_chk(8'h7c, 8'h00);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule : fsfb_bank_tb_top
